/* hw/adc_overrange_detector.v */
// Dual-channel overrange detector with AXI4-Lite register access
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "overrange_map.vh"

module adc_overrange_detector (
  input  wire                   aclk,
  input  wire                   aresetn,
  // AXI4-Lite write address
  input  wire [`AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]             s_axi_awprot,
  input  wire                   s_axi_awvalid,
  output reg                    s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]            s_axi_wdata,
  input  wire [3:0]             s_axi_wstrb,
  input  wire                   s_axi_wvalid,
  output reg                    s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]             s_axi_bresp,
  output reg                    s_axi_bvalid,
  input  wire                   s_axi_bready,
  // AXI4-Lite read address
  input  wire [`AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]             s_axi_arprot,
  input  wire                   s_axi_arvalid,
  output reg                    s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]            s_axi_rdata,
  output reg  [1:0]             s_axi_rresp,
  output reg                    s_axi_rvalid,
  input  wire                   s_axi_rready,
  // Converter samples, one per cycle when valid
  input  wire [`SAMPLE_W-1:0]   chan_a_sample,
  input  wire [`SAMPLE_W-1:0]   chan_b_sample,
  input  wire                   sample_valid,
  // Overrange pins
  output reg                    chan_a_first_flag_pin,
  output reg                    chan_a_second_flag_pin,
  output reg                    chan_b_first_flag_pin,
  output reg                    chan_b_second_flag_pin
);

  // Configuration registers
  reg  [7:0]             level_limit_first_q;
  reg  [7:0]             level_limit_second_q;
  reg  [7:0]             level_flag_setup_q;

  // Write channel holding state
  reg                    aw_held_q;
  reg  [`AXI_ADDR_W-1:0] aw_addr_q;
  reg                    w_held_q;
  reg  [7:0]             w_byte_q;
  reg                    w_lane0_q;
  wire                   aw_take;
  wire                   w_take;
  wire                   wr_fire;
  wire [9:0]             wr_idx;
  wire [9:0]             rd_idx;
  wire                   wr_hit;
  reg  [7:0]             rd_byte;
  reg                    rd_hit;

  // Detection datapath
  wire [`SAMPLE_W-1:0]   mag_a;
  wire [`SAMPLE_W-1:0]   mag_b;
  wire [`SAMPLE_W-1:0]   lvl_first;
  wire [`SAMPLE_W-1:0]   lvl_second;
  wire                   chan_a_first_limit_flag;
  wire                   chan_a_second_limit_flag;
  wire                   chan_b_first_limit_flag;
  wire                   chan_b_second_limit_flag;
  wire [3:0]             hit_vec;
  wire [3:0]             stretched;
  wire                   flag_pins_enable;
  wire [2:0]             flag_stretch_exponent;

  // Setup fields
  assign flag_pins_enable      = level_flag_setup_q[`SETUP_ENABLE_BIT];
  assign flag_stretch_exponent =
    level_flag_setup_q[`SETUP_EXP_MSB:`SETUP_EXP_LSB];

  // Handshake terms of the write path
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take  = s_axi_wvalid & s_axi_wready;
  assign wr_fire = aw_held_q & w_held_q & ~s_axi_bvalid;
  assign wr_idx  = aw_addr_q[`AXI_ADDR_W-1:2];
  assign rd_idx  = s_axi_araddr[`AXI_ADDR_W-1:2];
  assign wr_hit  = (wr_idx == `IDX_LIMIT_FIRST) |
                   (wr_idx == `IDX_LIMIT_SECOND) |
                   (wr_idx == `IDX_FLAG_SETUP);

  // Address and data are captured independently, in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q     <= 1'b0;
      aw_addr_q     <= {`AXI_ADDR_W{1'b0}};
      s_axi_awready <= 1'b0;
      w_held_q      <= 1'b0;
      w_byte_q      <= 8'h00;
      w_lane0_q     <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_held_q     <= 1'b1;
        aw_addr_q     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (wr_fire) begin
        aw_held_q     <= 1'b0;
        s_axi_awready <= 1'b1;
      end else if (!aw_held_q) begin
        s_axi_awready <= 1'b1;
      end
      if (w_take) begin
        w_held_q     <= 1'b1;
        w_byte_q     <= s_axi_wdata[7:0];
        w_lane0_q    <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end else if (wr_fire) begin
        w_held_q     <= 1'b0;
        s_axi_wready <= 1'b1;
      end else if (!w_held_q) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Register update and write response
  always @(posedge aclk) begin
    if (!aresetn) begin
      level_limit_first_q  <= `RST_LIMIT_FIRST;
      level_limit_second_q <= `RST_LIMIT_SECOND;
      level_flag_setup_q   <= `RST_FLAG_SETUP;
      s_axi_bvalid         <= 1'b0;
      s_axi_bresp          <= `AXI_RESP_OKAY;
    end else begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        if (w_lane0_q) begin
          if (wr_idx == `IDX_LIMIT_FIRST) begin
            level_limit_first_q <= w_byte_q;
          end
          if (wr_idx == `IDX_LIMIT_SECOND) begin
            level_limit_second_q <= w_byte_q;
          end
          if (wr_idx == `IDX_FLAG_SETUP) begin
            level_flag_setup_q <= w_byte_q & `SETUP_USED_MASK;
          end
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read decode; status word shows the live pin levels
  always @* begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    case (rd_idx)
      `IDX_LIMIT_FIRST:  rd_byte = level_limit_first_q;
      `IDX_LIMIT_SECOND: rd_byte = level_limit_second_q;
      `IDX_FLAG_SETUP:   rd_byte = level_flag_setup_q;
      `IDX_PIN_STATUS:   rd_byte = {4'h0, chan_b_second_flag_pin,
                                    chan_b_first_flag_pin,
                                    chan_a_second_flag_pin,
                                    chan_a_first_flag_pin};
      default:           rd_hit  = 1'b0;
    endcase
  end

  // Read channel: one request at a time, data one cycle after the address
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `AXI_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h000000, rd_byte};
        s_axi_rresp   <= rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Absolute sample level; the most negative code maps to full scale
  assign mag_a = chan_a_sample[`SAMPLE_W-1] ?
                 (~chan_a_sample + {{(`SAMPLE_W-1){1'b0}}, 1'b1}) :
                 chan_a_sample;
  assign mag_b = chan_b_sample[`SAMPLE_W-1] ?
                 (~chan_b_sample + {{(`SAMPLE_W-1){1'b0}}, 1'b1}) :
                 chan_b_sample;

  // Limit T is T/256 of full scale (2048 codes), i.e. T*8 codes
  assign lvl_first  = {1'b0, level_limit_first_q,
                       {`LIMIT_SCALE_SHIFT{1'b0}}};
  assign lvl_second = {1'b0, level_limit_second_q,
                       {`LIMIT_SCALE_SHIFT{1'b0}}};

  // Level comparisons; reaching the limit counts as a hit
  assign chan_a_first_limit_flag  = sample_valid & (mag_a >= lvl_first);
  assign chan_b_first_limit_flag  = sample_valid & (mag_b >= lvl_first);
  assign chan_a_second_limit_flag =
    sample_valid & (mag_a >= lvl_second);
  assign chan_b_second_limit_flag =
    sample_valid & (mag_b >= lvl_second);

  // Pin order: A first, A second, B first, B second
  assign hit_vec = {chan_b_second_limit_flag, chan_b_first_limit_flag,
                    chan_a_second_limit_flag, chan_a_first_limit_flag};

  // One stretcher per pin, sharing the exponent
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_str
      flag_stretcher u_str (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .hit         (hit_vec[gi]),
        .stretch_exp (flag_stretch_exponent),
        .flag        (stretched[gi])
      );
    end
  endgenerate

  // Registered pins, forced low while disabled
  always @(posedge aclk) begin
    if (!aresetn) begin
      chan_a_first_flag_pin  <= 1'b0;
      chan_a_second_flag_pin <= 1'b0;
      chan_b_first_flag_pin  <= 1'b0;
      chan_b_second_flag_pin <= 1'b0;
    end else begin
      chan_a_first_flag_pin  <= flag_pins_enable & stretched[0];
      chan_a_second_flag_pin <= flag_pins_enable & stretched[1];
      chan_b_first_flag_pin  <= flag_pins_enable & stretched[2];
      chan_b_second_flag_pin <= flag_pins_enable & stretched[3];
    end
  end

endmodule

/* hw/flag_stretcher.v */
// Pulse stretcher that holds a flag for 8 * 2^exp cycles after each hit
`timescale 1ns/1ps
`include "overrange_map.vh"

module flag_stretcher (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       hit,
  input  wire [2:0] stretch_exp,
  output wire       flag
);

  reg  [`STRETCH_CNT_W-1:0] cnt_q;
  reg  [`STRETCH_CNT_W-1:0] cnt_d;
  wire [`STRETCH_CNT_W-1:0] len;

  // Pulse length from the exponent field
  assign len = `STRETCH_BASE << stretch_exp;

  // Reload on every hit, otherwise count down to zero
  always @* begin
    cnt_d = cnt_q;
    if (hit) begin
      cnt_d = len;
    end else if (cnt_q != {`STRETCH_CNT_W{1'b0}}) begin
      cnt_d = cnt_q - {{(`STRETCH_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= {`STRETCH_CNT_W{1'b0}};
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Flag stands while the count is running
  assign flag = (cnt_q != {`STRETCH_CNT_W{1'b0}});

endmodule

/* inc/overrange_map.vh */
// Register map, field layout, reset values and counts of the overrange block
//
// Behaviour
// - First limit flag of A or B sets when magnitude reaches first limit; reset 0xF2.
// - Limit T means peak level T/256 of full scale, 20*log10(T/256) dBFS.
// - Second limit flag of A or B sets when magnitude reaches second limit; reset 0xAB.
// - Three-bit stretch exponent in setup bits 2..0, reset 0x7, for all pins.
// - Each pin pulse lasts at least 8 * 2^exponent sample-clock cycles.
`ifndef OVERRANGE_MAP_VH
`define OVERRANGE_MAP_VH

// Printed register indices; byte address is four times the index
`define IDX_LIMIT_FIRST     10'h211
`define IDX_LIMIT_SECOND    10'h212
`define IDX_FLAG_SETUP      10'h213
`define IDX_PIN_STATUS      10'h214

// Bus geometry
`define AXI_ADDR_W          12
`define AXI_RESP_OKAY       2'h0
`define AXI_RESP_SLVERR     2'h2

// Reset values
`define RST_LIMIT_FIRST     8'hF2
`define RST_LIMIT_SECOND    8'hAB
`define RST_FLAG_SETUP      8'h07

// Setup register fields
`define SETUP_ENABLE_BIT    3
`define SETUP_EXP_LSB       0
`define SETUP_EXP_MSB       2
`define SETUP_USED_MASK     8'h0F

// Sample geometry: 12-bit two's complement, limit scaled by 2^(12-1-8)
`define SAMPLE_W            12
`define LIMIT_SCALE_SHIFT   3

// Stretch length base: pulse is this many cycles shifted left by exponent
`define STRETCH_BASE        11'h008
`define STRETCH_CNT_W       11

`endif

/* verification/overrange_checks_assertions.sv */
// Port checker of the overrange detector
`timescale 1ns/1ps
module overrange_checks (
  input wire        aclk,
  input wire        aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        sample_valid,
  input wire        chan_a_first_flag_pin,
  input wire        chan_a_second_flag_pin,
  input wire        chan_b_first_flag_pin,
  input wire        chan_b_second_flag_pin
);
  reg        en_q;
  reg [2:0]  ex_q;
  reg [11:0] run_q;
  wire       wr = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
  wire [3:0] pins = {chan_b_second_flag_pin, chan_b_first_flag_pin,
                     chan_a_second_flag_pin, chan_a_first_flag_pin};
  // Mirror of enable and exponent, and run length of one pin
  always @(posedge aclk) begin
    run_q <= chan_a_first_flag_pin ? run_q + 12'h001 : 12'h000;
    if (!aresetn) begin
      en_q <= 1'b0;
      ex_q <= 3'h7;
    end else if (wr && s_axi_awaddr == 12'h84C) begin
      en_q <= s_axi_wdata[3];
      ex_q <= s_axi_wdata[2:0];
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_OFF: assert property (!en_q && !$past(en_q) && !$past(en_q, 2)
    |-> pins == 4'h0) else $error("pin high while disabled");
  AST_STRETCH: assert property ($fell(chan_a_first_flag_pin) && en_q
    && $past(en_q, 2) |-> run_q >= (12'h008 << ex_q)) else $error("short");
  AST_MIN8: assert property ($rose(chan_b_first_flag_pin) && en_q
    |-> chan_b_first_flag_pin [*8]) else $error("pulse under 8");
  AST_A1: assert property ($rose(chan_a_first_flag_pin) && $past(en_q, 3)
    |-> $past(sample_valid, 2)) else $error("a first without sample");
  AST_A2: assert property ($rose(chan_a_second_flag_pin) && $past(en_q, 3)
    |-> $past(sample_valid, 2)) else $error("a second without sample");
  AST_B2: assert property ($rose(chan_b_second_flag_pin) && $past(en_q, 3)
    |-> $past(sample_valid, 2)) else $error("b second without sample");
  AST_WTIME: assert property (wr |-> ##[1:2] s_axi_bvalid)
    else $error("no write response");
  AST_WBUSY: assert property (wr |=> !s_axi_awready && !s_axi_wready)
    else $error("ready during write");
endmodule
bind adc_overrange_detector overrange_checks chk (.*);

/* verification/pin_watcher.sv */
// Host-side logic that measures how long the flag pins stay active
`timescale 1ns/1ps
module pin_watcher (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [3:0]  pins,
  output reg  [11:0] last_len
);
  reg [11:0] cnt_q;
  // Count active cycles, latch the run length when all pins drop
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 12'h000;
      last_len <= 12'h000;
    end else if (|pins) begin
      cnt_q <= cnt_q + 12'h001;
    end else if (cnt_q != 12'h000) begin
      last_len <= cnt_q;
      cnt_q <= 12'h000;
    end
  end
endmodule

/* verification/test_adc_overrange_detector.sv */
// Self-checking bench of the overrange detector
`timescale 1ns/1ps
module test_adc_overrange_detector;
  reg         aclk = 1'b0;
  reg         aresetn = 1'b0;
  reg  [11:0] addr = 12'h000;
  reg  [31:0] wdata = 32'h0;
  reg  [3:0]  strb = 4'hF;
  reg         awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, valid = 1'b0;
  reg  [11:0] sa = 12'h000, sb = 12'h000;
  wire        awready, wready, bvalid, arready, rvalid;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [3:0]  pins;
  wire [11:0] len;
  reg  [27:0] rows [0:3] = '{{12'h100, 12'h0FF, 4'h1},
    {12'hF00, 12'h200, 4'hD}, {12'h800, 12'h000, 4'h3},
    {12'h000, 12'h7FF, 4'hC}};
  integer     n_fail = 0, compares = 0, i;
  // Sample clock
  initial forever #25 aclk = ~aclk;
  // Device under test and host-side monitor
  adc_overrange_detector dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(addr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(addr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .chan_a_sample(sa), .chan_b_sample(sb), .sample_valid(valid),
    .chan_a_first_flag_pin(pins[0]), .chan_a_second_flag_pin(pins[1]),
    .chan_b_first_flag_pin(pins[2]), .chan_b_second_flag_pin(pins[3]));
  pin_watcher host (.aclk(aclk), .aresetn(aresetn), .pins(pins),
    .last_len(len));
  task end_sim;
    begin
      if (n_fail == 0 && compares > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task cmp(input string nm, input [31:0] ex, input [31:0] got);
    begin
      compares = compares + 1;
      if (got !== ex) begin
        $display("wrong value %s expected %h seen %h", nm, ex, got);
        n_fail = n_fail + 1;
      end
    end
  endtask
  // One register write or read, held until each channel is taken
  task bus(input w, input [11:0] a, input [31:0] d, input [1:0] r);
    integer    k;
    reg        ta, tw, tr, done;
    reg [31:0] rv;
    reg [1:0]  rs;
    begin
      @(posedge aclk);
      addr <= a;
      wdata <= d;
      awvalid <= w;
      wvalid <= w;
      arvalid <= !w;
      done = 1'b0;
      for (k = 0; k < 40 && !done; k = k + 1) begin
        #1;
        ta = awready & awvalid;
        tw = wready & wvalid;
        tr = arready & arvalid;
        done = w ? bvalid : rvalid;
        rv = rdata;
        rs = w ? bresp : rresp;
        @(posedge aclk);
        if (ta) awvalid <= 1'b0;
        if (tw) wvalid <= 1'b0;
        if (tr) arvalid <= 1'b0;
      end
      if (!done) begin
        n_fail = n_fail + 1;
        end_sim;
      end else begin
        cmp("resp", r, rs);
        if (!w) cmp("rdata", d, rv);
      end
    end
  endtask
  // One valid sample on both channels
  task hit(input [11:0] a, input [11:0] b);
    begin
      @(posedge aclk);
      sa <= a;
      sb <= b;
      valid <= 1'b1;
      @(posedge aclk);
      valid <= 1'b0;
    end
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    bus(0, 12'h844, 32'hF2, 2'h0);
    bus(0, 12'h848, 32'hAB, 2'h0);
    bus(0, 12'h84C, 32'h07, 2'h0);
    bus(0, 12'h900, 32'h00, 2'h2);
    bus(1, 12'h900, 32'h01, 2'h2);
    hit(12'h800, 12'h800);
    repeat (2) @(posedge aclk);
    #1 cmp("pins", 4'h0, pins);
    repeat (1100) @(posedge aclk);
    bus(1, 12'h844, 32'h20, 2'h0);
    bus(1, 12'h848, 32'h40, 2'h0);
    bus(1, 12'h84C, 32'hF8, 2'h0);
    bus(0, 12'h84C, 32'h08, 2'h0);
    // Samples against limits of 256 and 512 sample units
    for (i = 0; i < 4; i = i + 1) begin
      hit(rows[i][27:16], rows[i][15:4]);
      repeat (2) @(posedge aclk);
      #1 cmp("pins", rows[i][3:0], pins);
      repeat (12) @(posedge aclk);
    end
    // Every exponent, ending on the largest
    for (i = 0; i < 8; i = i + 1) begin
      bus(1, 12'h84C, 32'h8 + i, 2'h0);
      hit(12'h100, 12'h000);
      repeat ((8 << i) + 6) @(posedge aclk);
      cmp("len", 8 << i, len);
    end
    // A second hit mid-pulse restarts the stretch
    bus(1, 12'h84C, 32'h0A, 2'h0);
    hit(12'h100, 12'h000);
    repeat (10) @(posedge aclk);
    hit(12'h100, 12'h000);
    repeat (50) @(posedge aclk);
    cmp("len", 44, len);
    // Enable with the largest exponent and start a long pulse on both A pins
    bus(1, 12'h84C, 32'h0F, 2'h0);
    hit(12'h800, 12'h000);
    repeat (20) @(posedge aclk);
    // Status word shows the live pins; it refuses writes; clearing the enable mid-pulse drops the pins
    bus(0, 12'h850, 32'h03, 2'h0);
    bus(1, 12'h850, 32'h00, 2'h2);
    bus(1, 12'h84C, 32'h07, 2'h0);
    #1 cmp("pins", 4'h0, pins);
    // Reset in mid-run idles the bus and restores the defaults
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    #1 cmp("idle", 32'h0, {awready, wready, arready, bvalid, rvalid, pins});
    @(posedge aclk);
    aresetn <= 1'b1;
    bus(0, 12'h844, 32'hF2, 2'h0);
    bus(0, 12'h848, 32'hAB, 2'h0);
    bus(0, 12'h84C, 32'h07, 2'h0);
    // A write without byte lane 0 stores nothing
    strb <= 4'hE;
    bus(1, 12'h844, 32'h55, 2'h0);
    bus(0, 12'h844, 32'hF2, 2'h0);
    end_sim;
  end
endmodule
